// ### dv/ccp_charge_ctrl_test.sv
/* Bench for the charge control block: registers, charge cycle, pin, interrupt.
   Assumes the far side model in ccp_far_side. */
module ccp_charge_ctrl_test
   import ccp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] BAT[3] = '{16'h05DC, 16'h09C4, 16'h0DAC};
   localparam ccp_src_t    SRC[3] = '{SRC_FIXED, SRC_PRE, SRC_FAST};
   localparam logic [1:0]  PH[3]  = '{PH_PRE, PH_PRE, PH_FAST};
   logic        mclk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        rd_d = 1'b0;
   logic        chg_en_n_in = 1'b1;
   logic        over = 1'b0;
   logic        cold = 1'b0;
   logic        taper = 1'b0;
   logic [15:0] bat_mv = 16'h0FA0;
   ccp_addr_t   addr_in = 4'h0;
   ccp_byte_t   wdata_in = 8'h00;
   ccp_byte_t   rdata_out;
   ccp_byte_t   v;
   ccp_byte_t   exp_q[$];
   ccp_byte_t   msk_q[$];
   ccp_sense_t  sense;
   ccp_src_t    src;
   logic [5:0]  thr;
   logic        oe;
   logic        stat_pin;
   logic        int_out;
   logic        bat_sw;
   logic        half;
   ccp_limits_t lim;
   int          errors = 0;
   int          n_compared = 0;
   int          w;

   ccp_charge_ctrl #(.BLINK_CYC(8), .STEP_CYC(2), .PULSE_CYC(16)) u_ccp_charge_ctrl (
      .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sense_in(sense),
      .chg_en_n_in(chg_en_n_in), .limits_out(lim), .chg_src_out(src), .throttle_out(thr),
      .bat_sw_on_out(bat_sw), .timer_half_out(half), .timer_restart_out(), .stat_out(),
      .stat_oe_out(oe), .int_out(int_out));
   ccp_far_side u_ccp_far_side (.bat_mv_in(bat_mv), .over_in(over), .cold_in(cold),
      .taper_in(taper), .stat_oe_in(oe), .sense_out(sense), .stat_pin_out(stat_pin));

   initial begin
      forever #50 mclk_in = ~mclk_in;
   end

   task automatic chk(string nm, ccp_byte_t e, ccp_byte_t s);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic wr(ccp_addr_t a, ccp_byte_t d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   // Expectation noted before the strobe; the monitor pops it
   task automatic rd(ccp_addr_t a, ccp_byte_t m, ccp_byte_t e);
      @(posedge mclk_in);
      exp_q.push_back(e);
      msk_q.push_back(m);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge mclk_in) rd_d <= rd_in;
   // Data stands only in the cycle after the strobe
   always @(negedge mclk_in) begin
      if (rd_d) chk("rdata", exp_q.pop_front(), rdata_out & msk_q.pop_front());
   end

   initial begin
      repeat (20000) @(posedge mclk_in);
      errors++;
      complete_run();
   end

   initial begin
      void'($urandom(29788));
      cyc(8);
      rst_in <= 1'b0;
      rd(REG_INLIM, 8'hFF, RST_INLIM);
      rd(REG_PWRCFG, 8'h30, 8'h10);
      rd(REG_FASTCUR, 8'hFF, RST_FASTCUR);
      rd(REG_PRETERM, 8'hFF, RST_PRETERM);
      chk("fast_cur", RST_FASTCUR >> FAST_LSB, {2'b00, lim.fast_cur});
      rd(4'hB, 8'hFF, 8'h00);
      v = 8'($urandom);
      wr(REG_PRETERM, v);
      rd(REG_PRETERM, 8'hFF, v);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         chg_en_n_in <= 1'b1;
         cyc(8);
         rd(REG_STATUS, 8'h30, 8'h00);
         @(negedge mclk_in);
         chk("stat_off", 8'h01, {7'h0, stat_pin});
         cyc(1);
         bat_mv <= BAT[i];
         chg_en_n_in <= 1'b0;
         cyc(8);
         rd(REG_STATUS, 8'h30, {2'b00, PH[i], 4'h0});
         @(negedge mclk_in);
         chk("src", {6'h0, SRC[i]}, {6'h0, src});
         chk("stat_on", 8'h00, {7'h0, stat_pin});
         cyc(1);
      end
      $display("test phase select done");
      over <= 1'b1;
      cyc(12);
      rd(REG_STATUS, 8'h08, 8'h08);
      @(negedge mclk_in);
      chk("thr_down", 8'h01, {7'h0, thr < 6'h3F});
      chk("half", 8'h01, {7'h0, half});
      cyc(1);
      over <= 1'b0;
      wr(REG_TERMTMR, 8'h1A);
      wr(REG_FASTCUR, RST_FASTCUR | 8'h01);
      bat_mv <= 16'h1068;
      taper <= 1'b1;
      cyc(12);
      chk("low_cur", 8'h01, {7'h0, lim.low_cur});
      rd(REG_STATUS, 8'h30, 8'h20);
      wr(REG_FASTCUR, RST_FASTCUR);
      wr(REG_TERMTMR, RST_TERMTMR);
      for (w = 0; w < 30 && int_out !== 1'b1; w++) @(negedge mclk_in);
      for (w = 0; w < 40 && int_out === 1'b1; w++) @(negedge mclk_in);
      chk("int_len", 8'h10, 8'(w));
      rd(REG_STATUS, 8'h30, 8'h30);
      @(negedge mclk_in);
      chk("stat_done", 8'h01, {7'h0, stat_pin});
      chk("sw_done", 8'h00, {7'h0, bat_sw});
      cyc(1);
      bat_mv <= 16'h0FA0;
      taper <= 1'b0;
      cyc(10);
      rd(REG_STATUS, 8'h30, 8'h20);
      $display("test termination done");
      cold <= 1'b1;
      cyc(6);
      v = 8'h00;
      for (w = 0; w < 40; w++) begin
         @(negedge mclk_in);
         v += {7'h0, stat_pin};
      end
      chk("blink", 8'h01, {7'h0, v > 0 && v < 40});
      rd(REG_FAULT, 8'h01, 8'h01);
      rd(REG_STATUS, 8'h30, 8'h00);
      cold <= 1'b0;
      cyc(10);
      rd(REG_STATUS, 8'h30, 8'h20);
      cyc(2);
      $display("test thermistor done");
      complete_run();
   end
endmodule

// ### dv/ccp_far_side.sv
/* Far side model: battery, input source, thermistor, status pin.
   Assumes bench knobs are levels; the status pin has a pull-up. */
module ccp_far_side
   import ccp_pkg::*;
(
   // Bench knobs
   input  wire logic [15:0] bat_mv_in,
   input  wire logic        over_in,
   input  wire logic        cold_in,
   input  wire logic        taper_in,
   // Device side
   input  wire logic        stat_oe_in,
   output ccp_sense_t       sense_out,
   output logic             stat_pin_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      sense_out = '0;
      sense_out.in_over_cur = over_in;
      sense_out.bat_below_2v = bat_mv_in < 16'h07D0;
      sense_out.bat_below_3v = bat_mv_in < 16'h0BB8;
      // Recharge level fixed, not taken from the select bit
      sense_out.bat_above_rechg = bat_mv_in > 16'h1004;
      sense_out.cur_below_term = taper_in;
      sense_out.conv_run = 1'b1;
      sense_out.ts_a_cold = cold_in;
   end
   // Released pin floats up
   assign stat_pin_out = stat_oe_in ? 1'b0 : 1'b1;
endmodule

// ### src/ccp_charge_ctrl.sv
/*
 * Charge-cycle and power-path control: input power management back-off,
 * supplement mode, charge state machine, status pin, status and fault
 * registers, interrupt pulse. Assumes comparator flags and the charge enable
 * pin arrive asynchronously, and a register port on the same 10 MHz clock.
 */
// Our own choices: the register offsets and the plain strobed port.
// Overview of operation
// - Overload is over-current or under-voltage on input
// - Lower charge current while input stays overloaded
// - Zero current, overload, low system: enter supplement
// - Power management status bit follows either regulation
// - Leave supplement when battery is depleted
// - Charge field resets to the enable code
// - Default charge settings load at reset
// - Start only with all enable conditions met
// - Terminate on low current above recharge level
// - Restart charging when battery drops below recharge
// - Status pin low charging, high idle, blinks faulted
// - Phase field reports disabled, pre, fast, done
// - Termination reports done and raises interrupt
// - Pick charge current by battery voltage at start
// - Regulation suspends termination and halves timer rate
// - Thermistor window gates start, suspend and resume
// - Thermistor fault recorded, interrupt, status pin shows
// - After done switch off, supplement still allowed
// - Termination skipped while its enable is zero
// - Every interrupt is one 256 us pulse; an event inside a pulse restarts it
module ccp_charge_ctrl
   import ccp_pkg::*;
#(
   parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
   parameter int unsigned STEP_CYC  = THR_STEP_CYC,
   parameter int unsigned PULSE_CYC = INT_PULSE_CYC
) (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // Register port
   input  wire ccp_addr_t   addr_in,
   input  wire ccp_byte_t   wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output ccp_byte_t        rdata_out,
   // Analog comparator flags and charge enable pin, asynchronous
   input  wire ccp_sense_t  sense_in,
   input  wire logic        chg_en_n_in,
   // Settings and controls toward the analog loops
   output ccp_limits_t      limits_out,
   output ccp_src_t         chg_src_out,
   output logic [5:0]       throttle_out,
   output logic             bat_sw_on_out,
   output logic             timer_half_out,
   output logic             timer_restart_out,
   // Open-drain status pin and interrupt
   output logic             stat_out,
   output logic             stat_oe_out,
   output logic             int_out
);
   localparam int unsigned SW = $clog2(STEP_CYC + 1);
   localparam int unsigned BW = $clog2(BLINK_CYC + 1);

   ccp_sense_t  s_m_r;
   ccp_sense_t  s_r;
   logic        ce_n_m_r;
   logic        ce_n_r;
   ccp_byte_t   inlim_r;
   ccp_byte_t   pwrcfg_r;
   ccp_byte_t   fastcur_r;
   ccp_byte_t   preterm_r;
   ccp_byte_t   chgvolt_r;
   ccp_byte_t   termtmr_r;
   ccp_byte_t   miscop_r;
   ccp_byte_t   rdata_r;
   ccp_byte_t   rd_nxt;
   ccp_state_t  st_r;
   ccp_state_t  st_nxt;
   ccp_src_t    src_r;
   logic [5:0]  thr_r;
   logic [SW-1:0] step_cnt_r;
   logic        step_r;
   logic [BW-1:0] blink_cnt_r;
   logic        blink_r;
   logic        supp_r;
   logic        bat_sw_r;
   logic        half_r;
   logic        restart_r;
   logic        stat_low_r;
   logic [2:0]  fault_r;
   logic        tf_d_r;
   logic        evt_r;
   logic        ovl;
   logic [1:0]  chg_field;
   logic        force_off;
   logic        enabled;
   logic        ts_start_ok;
   logic        ts_run_bad;
   logic        start_ok;
   logic        charging;
   logic        term_ok;
   logic        cycle_start;
   logic        enter_susp;
   logic        enter_done;
   logic        fault_halt;
   logic        rd_fault;

   function automatic ccp_state_t pick_state(input ccp_sense_t s);
      pick_state = s.bat_below_3v ? ST_PRE : ST_FAST;
   endfunction

   function automatic ccp_src_t pick_src(input ccp_sense_t s);
      if (s.bat_below_2v) begin
         pick_src = SRC_FIXED;
      end else if (s.bat_below_3v) begin
         pick_src = SRC_PRE;
      end else begin
         pick_src = SRC_FAST;
      end
   endfunction

   function automatic logic [1:0] phase_of(input ccp_state_t st);
      case (st)
         ST_PRE:  phase_of = PH_PRE;
         ST_FAST: phase_of = PH_FAST;
         ST_DONE: phase_of = PH_DONE;
         default: phase_of = PH_DIS;
      endcase
   endfunction

   // Pin and comparator synchronisers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_m_r    <= '0;
         s_r      <= '0;
         ce_n_m_r <= 1'b1;
         ce_n_r   <= 1'b1;
      end else begin
         s_m_r    <= sense_in;
         s_r      <= s_m_r;
         ce_n_m_r <= chg_en_n_in;
         ce_n_r   <= ce_n_m_r;
      end
   end

   // Writable registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         inlim_r   <= RST_INLIM;
         pwrcfg_r  <= RST_PWRCFG;
         fastcur_r <= RST_FASTCUR;
         preterm_r <= RST_PRETERM;
         chgvolt_r <= RST_CHGVOLT;
         termtmr_r <= RST_TERMTMR;
         miscop_r  <= RST_MISCOP;
      end else if (wr_in) begin
         case (addr_in)
            REG_INLIM:   inlim_r   <= wdata_in;
            REG_PWRCFG:  pwrcfg_r  <= wdata_in;
            REG_FASTCUR: fastcur_r <= wdata_in;
            REG_PRETERM: preterm_r <= wdata_in;
            REG_CHGVOLT: chgvolt_r <= wdata_in;
            REG_TERMTMR: termtmr_r <= wdata_in;
            REG_MISCOP:  miscop_r  <= wdata_in;
            default: ;
         endcase
      end
   end

   assign limits_out.in_cur_lim  = inlim_r[ILIM_LSB +: 3];
   assign limits_out.in_volt_lim = inlim_r[VLIM_LSB +: 4];
   assign limits_out.fast_cur    = fastcur_r[FAST_LSB +: 6];
   assign limits_out.pre_cur     = preterm_r[PRE_LSB +: 4];
   assign limits_out.term_cur    = preterm_r[TERM_LSB +: 4];
   assign limits_out.chg_volt    = chgvolt_r[VREG_LSB +: 6];
   assign limits_out.rechg_sel   = chgvolt_r[RECHG_BIT];
   assign limits_out.low_cur     = fastcur_r[LOWCUR_BIT];

   // Start and run conditions
   assign ovl         = s_r.in_over_cur | s_r.in_under_volt;
   assign chg_field   = pwrcfg_r[CHG_CFG_LSB +: 2];
   assign force_off   = miscop_r[FORCE_OFF_BIT];
   assign enabled     = s_r.conv_run & (chg_field == CFG_CHG_EN) & ~ce_n_r
                        & ~s_r.timer_fault & ~force_off;
   assign ts_start_ok = ~(s_r.ts_a_cold | s_r.ts_a_warm | s_r.ts_b_cold | s_r.ts_b_warm);
   assign ts_run_bad  = s_r.ts_a_cold | s_r.ts_a_hot | s_r.ts_b_cold | s_r.ts_b_hot;
   assign start_ok    = enabled & ts_start_ok;
   assign charging    = (st_r == ST_PRE) || (st_r == ST_FAST);
   // Regulation hides the real current, so termination would fire falsely
   assign term_ok     = termtmr_r[TERM_EN_BIT] & ~ovl & ~s_r.thermal_reg
                        & s_r.cur_below_term & s_r.bat_above_rechg;

   // Charge cycle state machine
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_OFF: begin
            if (start_ok) begin
               st_nxt = pick_state(s_r);
            end
         end
         ST_PRE, ST_FAST: begin
            if (!enabled) begin
               st_nxt = ST_OFF;
            end else if (ts_run_bad) begin
               st_nxt = ST_SUSP;
            end else if (term_ok) begin
               st_nxt = ST_DONE;
            end else if (st_r == ST_PRE && !s_r.bat_below_3v) begin
               st_nxt = ST_FAST;
            end
         end
         ST_SUSP: begin
            if (!enabled) begin
               st_nxt = ST_OFF;
            end else if (ts_start_ok) begin
               st_nxt = pick_state(s_r);
            end
         end
         ST_DONE: begin
            if (!enabled) begin
               st_nxt = ST_OFF;
            end else if (!s_r.bat_above_rechg && ts_start_ok) begin
               st_nxt = pick_state(s_r);
            end
         end
         default: st_nxt = ST_OFF;
      endcase
   end

   assign cycle_start = !charging && (st_nxt == ST_PRE || st_nxt == ST_FAST);
   assign enter_susp  = (st_r != ST_SUSP) && (st_nxt == ST_SUSP);
   assign enter_done  = (st_r != ST_DONE) && (st_nxt == ST_DONE);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_r      <= ST_OFF;
         src_r     <= SRC_FIXED;
         restart_r <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         restart_r <= cycle_start;
         if (cycle_start) begin
            src_r <= pick_src(s_r);
         end else if (st_r == ST_PRE && st_nxt == ST_FAST) begin
            src_r <= SRC_FAST;
         end
      end
   end

   // Back-off step enable
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         step_cnt_r <= '0;
         step_r     <= 1'b0;
      end else begin
         step_r <= (step_cnt_r == SW'(STEP_CYC - 1));
         if (step_cnt_r == SW'(STEP_CYC - 1)) begin
            step_cnt_r <= '0;
         end else begin
            step_cnt_r <= step_cnt_r + 1'b1;
         end
      end
   end

   // Charge current ceiling walks down under overload, back up when clear
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         thr_r <= THR_MAX;
      end else if (step_r) begin
         if (ovl && thr_r != 6'h00) begin
            thr_r <= thr_r - 6'h01;
         end else if (!ovl && thr_r != THR_MAX) begin
            thr_r <= thr_r + 6'h01;
         end
      end
   end

   // Supplement mode; depletion wins so a flat battery is never drained
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         supp_r <= 1'b0;
      end else if (s_r.bat_below_deplete) begin
         supp_r <= 1'b0;
      end else if (thr_r == 6'h00 && ovl && s_r.sys_below_bat) begin
         supp_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         bat_sw_r <= 1'b0;
         half_r   <= 1'b0;
      end else begin
         bat_sw_r <= ~force_off & (charging | supp_r);
         half_r   <= charging & (ovl | s_r.thermal_reg);
      end
   end

   // Status pin blink divider
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end else if (blink_cnt_r == BW'(BLINK_CYC - 1)) begin
         blink_cnt_r <= '0;
         blink_r     <= ~blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 1'b1;
      end
   end

   assign fault_halt = (st_r == ST_SUSP)
                       | (s_r.timer_fault & (chg_field == CFG_CHG_EN) & ~ce_n_r);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         stat_low_r <= 1'b0;
      end else begin
         stat_low_r <= charging | (fault_halt & blink_r);
      end
   end

   // Thermistor fault record; a new fault beats a read-clear
   assign rd_fault = rd_in && (addr_in == REG_FAULT);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         fault_r <= 3'b000;
         tf_d_r  <= 1'b0;
         evt_r   <= 1'b0;
      end else begin
         fault_r <= (rd_fault ? 3'b000 : fault_r)
                    | (enter_susp ? {s_r.ts_b_cold | s_r.ts_b_hot, s_r.ts_a_hot, s_r.ts_a_cold}
                                  : 3'b000);
         tf_d_r  <= s_r.timer_fault;
         evt_r   <= enter_done | enter_susp | (s_r.timer_fault & ~tf_d_r);
      end
   end

   ccp_int_pulse #(
      .PULSE_CYC (PULSE_CYC)
   ) u_int (
      .mclk_in   (mclk_in),
      .rst_in    (rst_in),
      .evt_in    (evt_r),
      .pulse_out (int_out)
   );

   // Read path: data stands only in the cycle after the strobe
   always_comb begin
      rd_nxt = 8'h00;
      case (addr_in)
         REG_INLIM:   rd_nxt = inlim_r;
         REG_PWRCFG:  rd_nxt = pwrcfg_r;
         REG_FASTCUR: rd_nxt = fastcur_r;
         REG_PRETERM: rd_nxt = preterm_r;
         REG_CHGVOLT: rd_nxt = chgvolt_r;
         REG_TERMTMR: rd_nxt = termtmr_r;
         REG_MISCOP:  rd_nxt = miscop_r;
         REG_STATUS: begin
            rd_nxt[PHASE_LSB +: 2] = phase_of(st_r);
            rd_nxt[PWRMGT_BIT]     = ovl;
            rd_nxt[THERM_BIT]      = s_r.thermal_reg;
         end
         REG_FAULT:   rd_nxt = {5'b00000, fault_r};
         REG_PATH: begin
            rd_nxt[SUPP_BIT]  = supp_r;
            rd_nxt[BATSW_BIT] = bat_sw_r;
         end
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rd_in ? rd_nxt : 8'h00;
      end
   end

   assign rdata_out         = rdata_r;
   assign chg_src_out       = src_r;
   assign throttle_out      = thr_r;
   assign bat_sw_on_out     = bat_sw_r;
   assign timer_half_out    = half_r;
   assign timer_restart_out = restart_r;
   assign stat_out          = 1'b0;
   assign stat_oe_out       = stat_low_r;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   chk_status_pwrmgt: assert property (
      rd_in && addr_in == REG_STATUS |=> rdata_out[PWRMGT_BIT] == $past(ovl))
      else $error("power management status wrong");

   chk_backoff_step: assert property (
      step_r && ovl && thr_r != 6'h00 |=> thr_r == $past(thr_r) - 6'h01)
      else $error("charge current not lowered");

   chk_supp_enter: assert property (
      thr_r == 6'h00 && ovl && s_r.sys_below_bat && !s_r.bat_below_deplete
      |=> supp_r ##1 bat_sw_on_out || force_off)
      else $error("supplement mode not entered");

   chk_supp_exit: assert property (
      s_r.bat_below_deplete |=> !supp_r)
      else $error("supplement mode not left");

   chk_reset_cfg: assert property (
      $past(rst_in) |-> chg_field == CFG_CHG_EN && fastcur_r == RST_FASTCUR)
      else $error("reset defaults wrong");

   chk_start_gate: assert property (
      st_r == ST_OFF && !start_ok |=> st_r == ST_OFF)
      else $error("cycle started without conditions");

   chk_terminate: assert property (
      charging && enabled && !ts_run_bad && term_ok
      |=> st_r == ST_DONE ##[1:2] int_out)
      else $error("termination missed");

   chk_recharge: assert property (
      st_r == ST_DONE && start_ok && !s_r.bat_above_rechg
      |=> charging && timer_restart_out ##1 !timer_restart_out)
      else $error("recharge missed");

   chk_stat_charge: assert property (
      charging |=> stat_oe_out && !stat_out)
      else $error("status pin not low while charging");

   chk_phase_pick: assert property (
      st_r == ST_OFF && start_ok && s_r.bat_below_2v
      |=> st_r == ST_PRE && chg_src_out == SRC_FIXED && timer_restart_out)
      else $error("wrong start phase");

   chk_half_rate: assert property (
      charging && s_r.thermal_reg |=> timer_half_out)
      else $error("timer rate not halved");

   chk_ts_suspend: assert property (
      charging && enabled && ts_run_bad |=> st_r == ST_SUSP ##1 fault_r != 3'b000)
      else $error("thermistor suspend missed");

   chk_term_off: assert property (
      charging && !termtmr_r[TERM_EN_BIT] |=> st_r != ST_DONE)
      else $error("termination while disabled");

   chk_disable: assert property (
      st_r != ST_OFF && !enabled |=> st_r == ST_OFF ##1 !stat_oe_out || fault_halt)
      else $error("disable not honoured");

endmodule

// ### src/ccp_int_pulse.sv
/*
 * Interrupt pulse stretcher: turns a one-cycle event into a fixed-length pulse.
 * Assumes events come from logic on the same clock.
 */
module ccp_int_pulse
   import ccp_pkg::*;
#(
   parameter int unsigned PULSE_CYC = INT_PULSE_CYC
) (
   // Clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_in,
   // Event in, pulse out
   input  wire logic evt_in,
   output logic      pulse_out
);
   localparam int unsigned CW = $clog2(PULSE_CYC + 1);

   logic [CW-1:0] cnt_r;
   logic          pulse_r;
   logic [15:0]   hi_r;

   // A new event restarts the pulse; events inside one merge
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cnt_r   <= '0;
         pulse_r <= 1'b0;
      end else if (evt_in) begin
         cnt_r   <= CW'(PULSE_CYC);
         pulse_r <= 1'b1;
      end else begin
         if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end
         pulse_r <= (cnt_r > CW'(1));
      end
   end

   assign pulse_out = pulse_r;

   always_ff @(posedge mclk_in) begin
      if (rst_in || !pulse_r) begin
         hi_r <= '0;
      end else if (hi_r != 16'hFFFF) begin
         hi_r <= hi_r + 16'h0001;
      end
   end

   chk_pulse_width: assert property (@(posedge mclk_in) disable iff (rst_in)
      $fell(pulse_r) |-> ($past(hi_r) + 16'h0001) >= 16'(PULSE_CYC))
      else $error("interrupt pulse too short");

   chk_pulse_start: assert property (@(posedge mclk_in) disable iff (rst_in)
      evt_in |=> pulse_r)
      else $error("interrupt pulse did not start");

endmodule

// ### src/ccp_pkg.sv
/*
 * Shared constants and types for the charge-cycle and power-path control block:
 * register offsets, field positions, reset values, timing counts, state and
 * carrier types. Assumes a single 10 MHz clock domain.
 */
package ccp_pkg;

   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned INT_PULSE_NS   = 256_000;
   localparam int unsigned INT_PULSE_CYC  = INT_PULSE_NS / CLK_PERIOD_NS;
   localparam int unsigned THR_STEP_NS    = 1_000;
   localparam int unsigned THR_STEP_CYC   = THR_STEP_NS / CLK_PERIOD_NS;
   localparam int unsigned BLINK_HALF_NS  = 500_000_000;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

   typedef logic [3:0] ccp_addr_t;
   typedef logic [7:0] ccp_byte_t;

   // Register offsets
   localparam ccp_addr_t REG_INLIM   = 4'h0;
   localparam ccp_addr_t REG_PWRCFG  = 4'h1;
   localparam ccp_addr_t REG_FASTCUR = 4'h2;
   localparam ccp_addr_t REG_PRETERM = 4'h3;
   localparam ccp_addr_t REG_CHGVOLT = 4'h4;
   localparam ccp_addr_t REG_TERMTMR = 4'h5;
   localparam ccp_addr_t REG_MISCOP  = 4'h7;
   localparam ccp_addr_t REG_STATUS  = 4'h8;
   localparam ccp_addr_t REG_FAULT   = 4'h9;
   localparam ccp_addr_t REG_PATH    = 4'hA;

   // Field positions
   localparam int unsigned ILIM_LSB      = 0;
   localparam int unsigned VLIM_LSB      = 3;
   localparam int unsigned CHG_CFG_LSB   = 4;
   localparam int unsigned FAST_LSB      = 2;
   localparam int unsigned LOWCUR_BIT    = 0;
   localparam int unsigned PRE_LSB       = 4;
   localparam int unsigned TERM_LSB      = 0;
   localparam int unsigned VREG_LSB      = 2;
   localparam int unsigned RECHG_BIT     = 0;
   localparam int unsigned TERM_EN_BIT   = 7;
   localparam int unsigned FORCE_OFF_BIT = 5;
   localparam int unsigned PHASE_LSB     = 4;
   localparam int unsigned PWRMGT_BIT    = 3;
   localparam int unsigned THERM_BIT     = 1;
   localparam int unsigned SUPP_BIT      = 0;
   localparam int unsigned BATSW_BIT     = 1;

   // Reset values
   localparam ccp_byte_t RST_INLIM   = 8'h30;
   localparam ccp_byte_t RST_PWRCFG  = 8'h1B;
   localparam ccp_byte_t RST_FASTCUR = 8'h60;
   localparam ccp_byte_t RST_PRETERM = 8'h11;
   localparam ccp_byte_t RST_CHGVOLT = 8'hB2;
   localparam ccp_byte_t RST_TERMTMR = 8'h9A;
   localparam ccp_byte_t RST_MISCOP  = 8'h4B;

   localparam logic [1:0] CFG_CHG_EN = 2'b01;
   localparam logic [5:0] THR_MAX    = 6'h3F;

   // Charge phase codes
   localparam logic [1:0] PH_DIS  = 2'b00;
   localparam logic [1:0] PH_PRE  = 2'b01;
   localparam logic [1:0] PH_FAST = 2'b10;
   localparam logic [1:0] PH_DONE = 2'b11;

   typedef enum logic [4:0] {
      ST_OFF  = 5'b00001,
      ST_PRE  = 5'b00010,
      ST_FAST = 5'b00100,
      ST_DONE = 5'b01000,
      ST_SUSP = 5'b10000
   } ccp_state_t;

   typedef enum logic [1:0] {
      SRC_FIXED = 2'b00,
      SRC_PRE   = 2'b01,
      SRC_FAST  = 2'b10
   } ccp_src_t;

   // Comparator flags from the analog side
   typedef struct packed {
      logic in_over_cur;
      logic in_under_volt;
      logic thermal_reg;
      logic sys_below_bat;
      logic bat_below_deplete;
      logic bat_below_2v;
      logic bat_below_3v;
      logic bat_above_rechg;
      logic cur_below_term;
      logic conv_run;
      logic timer_fault;
      logic ts_a_cold;
      logic ts_a_warm;
      logic ts_a_hot;
      logic ts_b_cold;
      logic ts_b_warm;
      logic ts_b_hot;
   } ccp_sense_t;

   // Settings handed to the analog loops
   typedef struct packed {
      logic [2:0] in_cur_lim;
      logic [3:0] in_volt_lim;
      logic [5:0] fast_cur;
      logic [3:0] pre_cur;
      logic [3:0] term_cur;
      logic [5:0] chg_volt;
      logic       rechg_sel;
      logic       low_cur;
   } ccp_limits_t;

endpackage
